// File: cssm_pkg.sv
package cssm_pkg;

  // ****************************************
  // Register map, byte offsets
  // ****************************************
  localparam logic [2:0] ADDR_MODE   = 3'h0;  // serial_mode_reg
  localparam logic [2:0] ADDR_DIV    = 3'h1;  // bit_rate_divisor
  localparam logic [2:0] ADDR_CTRL   = 3'h2;  // serial_ctrl_reg
  localparam logic [2:0] ADDR_TXHOLD = 3'h3;  // tx_holding_reg
  localparam logic [2:0] ADDR_STAT   = 3'h4;  // serial_status_reg
  localparam logic [2:0] ADDR_RXHOLD = 3'h5;  // rx_holding_reg

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_SYNC   = 7;  // sync_mode_sel
  localparam int CTRL_TXEIE  = 7;  // tx_empty_irq_en
  localparam int CTRL_RXIE   = 6;  // rx_irq_en
  localparam int CTRL_TXEN   = 5;  // tx_enable_bit
  localparam int CTRL_RXEN   = 4;  // rx_enable_bit
  localparam int CTRL_MULTIPROC_ID_WAIT_EN   = 3;  // multiproc_id_wait_en
  localparam int CTRL_TXDIE  = 2;  // tx_done_irq_en
  localparam int CTRL_CKHI   = 1;  // clock_sel_hi
  localparam int CTRL_CKLO   = 0;  // clock_sel_lo
  localparam int STAT_TXE    = 7;  // tx_empty_flag
  localparam int STAT_RXF    = 6;  // rx_full_flag
  localparam int STAT_OVR    = 5;  // overrun_flag
  localparam int STAT_FER    = 4;  // framing_error_flag
  localparam int STAT_PER    = 3;  // parity_error_flag
  localparam int STAT_TXD    = 2;  // tx_done_flag

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_DIV  = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;  // Eight-bit character
  localparam logic [2:0] PRE_LAST = 3'h6;

  // Transmit sequencer states
  typedef enum logic [1:0] {
    CSSM_TX_IDLE  = 2'b00,
    CSSM_TX_READY = 2'b01,
    CSSM_TX_SHIFT = 2'b10
  } cssm_tx_type;

endpackage

// File: cssm_serial.sv
`timescale 1ns/1ps
module cssm_serial
  import cssm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic       dma_access,
  output logic      [7:0] reg_rdata,
  output logic            tx_pin,
  output logic            tx_pin_oe,
  input  wire logic       rx_pin,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  output logic            tx_empty_irq,
  output logic            tx_done_irq,
  output logic            rx_full_irq,
  output logic            rx_error_irq
);

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  mode_q;         // serial_mode_reg
  logic [7:0]  div_q;          // bit_rate_divisor
  logic [7:0]  ctrl_q;         // serial_ctrl_reg
  logic [7:0]  tx_hold_q;      // tx_holding_reg
  logic [7:0]  rx_hold_q;      // rx_holding_reg
  logic [7:0]  tx_shift_q;     // tx_shifter
  logic [7:0]  rx_shift_q;     // rx_shifter
  logic        tx_empty_q;     // Holding register free
  logic        tx_done_q;      // Last character finished
  logic        rx_full_q;      // Holding register has data
  logic        overrun_q;      // Lost character
  logic        fer_q;          // Framing error, clear only here
  logic        per_q;          // Parity error, clear only here
  cssm_tx_type tx_state_q;     // Transmit sequencer
  logic [2:0]  tx_cnt_q;       // Bit being driven
  logic [2:0]  rx_cnt_q;       // Bit being sampled
  logic        tx_pin_q;       // Line level
  logic        sck_gen_q;      // Internal clock level
  logic        sck_oe_q;       // Clock pin driven
  logic [7:0]  div_cnt_q;      // Half-period counter
  logic [7:0]  rdata_q;        // Read answer
  logic [3:0]  irq_q;          // Registered requests
  logic        sck_s1_q;       // Synchroniser stage 1
  logic        sck_s2_q;       // Synchroniser stage 2
  logic        sck_s3_q;       // Edge history
  logic        rx_s1_q;        // Synchroniser stage 1
  logic        rx_s2_q;        // Synchroniser stage 2

  // ****************************************
  // Decode
  // ****************************************
  wire wr_mode   = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_div    = reg_wr && (reg_addr == ADDR_DIV);
  wire wr_ctrl   = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_txhold = reg_wr && (reg_addr == ADDR_TXHOLD);
  wire wr_stat   = reg_wr && (reg_addr == ADDR_STAT);
  wire rd_rxhold = reg_rd && (reg_addr == ADDR_RXHOLD);

  // Control fields
  wire sync_sel  = mode_q[MODE_SYNC];
  wire te        = ctrl_q[CTRL_TXEN];
  wire re        = ctrl_q[CTRL_RXEN];
  // Internal clock unless the high select picks the pin
  wire int_clk   = sync_sel && !ctrl_q[CTRL_CKHI];
  wire err_any   = overrun_q || fer_q || per_q;
  wire te_clear  = wr_ctrl && !reg_wdata[CTRL_TXEN];

  // Software clears a flag by writing zero to it
  function automatic logic clr_bit(input logic wr, input logic [7:0] d, input int pos);
    clr_bit = wr && !d[pos];
  endfunction

  // ****************************************
  // Clock source and edge events
  // ****************************************
  // Receiver alone needs the internal clock only without transmitter
  wire rx_solo   = re && !te && !err_any;
  wire clk_need  = (tx_state_q != CSSM_TX_IDLE) || rx_solo;
  // A started pulse always finishes high, so the pin rests high
  wire gen_run   = int_clk && (clk_need || !sck_gen_q);
  wire gen_tick  = gen_run && (div_cnt_q == div_q);
  // External edges are acted on three mclk cycles after the pin moves
  wire ext_fall  = !sck_s2_q && sck_s3_q;
  wire ext_rise  = sck_s2_q && !sck_s3_q;
  wire fall_ev   = sync_sel && (int_clk ? (gen_tick && sck_gen_q) : ext_fall);
  wire rise_ev   = sync_sel && (int_clk ? (gen_tick && !sck_gen_q) : ext_rise);

  // Two flip-flops before any logic reads the pins
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      rx_s1_q  <= 1'b1;
      rx_s2_q  <= 1'b1;
    end
    else
    begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      rx_s1_q  <= rx_pin;
      rx_s2_q  <= rx_s1_q;
    end
  end

  // Divider: each tick toggles the internal clock, half period div+1
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt_q <= 8'h00;
      sck_gen_q <= 1'b1;
      sck_oe_q  <= 1'b0;
    end
    else
    begin
      sck_oe_q <= int_clk;
      if (!gen_run || gen_tick)
        div_cnt_q <= 8'h00;
      else
        div_cnt_q <= div_cnt_q + 8'h01;
      if (!int_clk)
        sck_gen_q <= 1'b1;
      else if (gen_tick)
        sck_gen_q <= !sck_gen_q;
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  // A new character is taken when idle or right after bit 7's rise
  wire tx_bit7   = (tx_state_q == CSSM_TX_SHIFT) && (tx_cnt_q == LAST_BIT);
  wire tx_avail  = te && sync_sel && !tx_empty_q && !err_any;
  wire tx_take   = tx_avail && ((tx_state_q == CSSM_TX_IDLE) || (tx_bit7 && rise_ev));
  wire tx_end    = tx_bit7 && rise_ev && !tx_avail;
  // Done is decided when bit 7 goes out on the line
  wire tx_done_set = fall_ev && (tx_state_q == CSSM_TX_SHIFT) && (tx_cnt_q == PRE_LAST)
                     && tx_empty_q;

  // Sequencer; eight pulses per character in either clock mode
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_state_q <= CSSM_TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_cnt_q   <= 3'h0;
      tx_pin_q   <= 1'b1;
    end
    else if (te_clear || !te)
    begin
      // Disable forces the transmitter back to its start point
      tx_state_q <= CSSM_TX_IDLE;
      tx_shift_q <= 8'h00;
      tx_cnt_q   <= 3'h0;
    end
    else if (tx_take)
    begin
      tx_shift_q <= tx_hold_q;
      tx_state_q <= CSSM_TX_READY;
    end
    else if (tx_end)
      tx_state_q <= CSSM_TX_IDLE;
    else if (fall_ev && (tx_state_q != CSSM_TX_IDLE) && !tx_bit7)
    begin
      // Each falling edge puts the next bit out, LSB first
      tx_pin_q   <= tx_shift_q[0];
      tx_shift_q <= {1'b0, tx_shift_q[7:1]};
      tx_cnt_q   <= (tx_state_q == CSSM_TX_READY) ? 3'h0 : tx_cnt_q + 3'h1;
      tx_state_q <= CSSM_TX_SHIFT;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  // Counter held at zero while off, so each start is aligned
  wire       rx_on     = re && sync_sel && !err_any;
  wire       rx_done   = rise_ev && rx_on && (rx_cnt_q == LAST_BIT);
  wire [7:0] rx_next   = {rx_s2_q, rx_shift_q[7:1]};
  wire       rx_copy   = rx_done && !rx_full_q;
  wire       ovr_set   = rx_done && rx_full_q;

  // Shift on every rising event while the receiver runs
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_cnt_q   <= 3'h0;
      rx_shift_q <= 8'h00;
    end
    else if (!rx_on)
      rx_cnt_q <= 3'h0;
    else if (rise_ev)
    begin
      rx_shift_q <= rx_next;
      rx_cnt_q   <= rx_cnt_q + 3'h1;
    end
  end

  // Holding register only changes on a clean copy
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_hold_q <= 8'h00;
    else if (rx_copy)
      rx_hold_q <= rx_next;
  end

  // ****************************************
  // Status flags; hardware set beats software clear
  // ****************************************
  // A DMA access beside the strobe clears the flag that started it
  wire txe_clr = clr_bit(wr_stat, reg_wdata, STAT_TXE) || (dma_access && wr_txhold);
  wire rxf_clr = clr_bit(wr_stat, reg_wdata, STAT_RXF) || (dma_access && rd_rxhold);

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_empty_q <= 1'b1;
      tx_done_q  <= 1'b0;
      rx_full_q  <= 1'b0;
      overrun_q  <= 1'b0;
      fer_q      <= 1'b0;
      per_q      <= 1'b0;
    end
    else
    begin
      tx_empty_q <= te_clear || tx_take || (tx_empty_q && !txe_clr);
      tx_done_q  <= tx_done_set || (tx_done_q && !tx_take
                    && !clr_bit(wr_stat, reg_wdata, STAT_TXD));
      rx_full_q  <= rx_copy || (rx_full_q && !rxf_clr);
      overrun_q  <= ovr_set || (overrun_q && !clr_bit(wr_stat, reg_wdata, STAT_OVR));
      fer_q      <= fer_q && !clr_bit(wr_stat, reg_wdata, STAT_FER);
      per_q      <= per_q && !clr_bit(wr_stat, reg_wdata, STAT_PER);
    end
  end

  // ****************************************
  // Configuration and holding writes
  // ****************************************
  // Format bits other than sync select are stored but never used
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_q    <= RST_MODE;
      div_q     <= RST_DIV;
      ctrl_q    <= RST_CTRL;
      tx_hold_q <= 8'h00;
    end
    else
    begin
      if (wr_mode)
        mode_q <= reg_wdata;
      if (wr_div)
        div_q <= reg_wdata;
      if (wr_ctrl)
        ctrl_q <= reg_wdata;
      // Writing while not empty overwrites the pending character
      if (wr_txhold)
        tx_hold_q <= reg_wdata;
    end
  end

  // ****************************************
  // Read port and requests
  // ****************************************
  // Status view; the two low bits always read zero
  wire [7:0] stat_rd = {tx_empty_q, rx_full_q, overrun_q, fer_q, per_q, tx_done_q, 2'b00};
  // Unmapped offsets answer zero
  wire [7:0] rd_mux  = (reg_addr == ADDR_MODE)   ? mode_q    :
                       (reg_addr == ADDR_DIV)    ? div_q     :
                       (reg_addr == ADDR_CTRL)   ? ctrl_q    :
                       (reg_addr == ADDR_TXHOLD) ? tx_hold_q :
                       (reg_addr == ADDR_STAT)   ? stat_rd   :
                       (reg_addr == ADDR_RXHOLD) ? rx_hold_q : 8'h00;
  // Error request has priority and replaces the full request
  wire [3:0] irq_d = {tx_empty_q && ctrl_q[CTRL_TXEIE],
                      tx_done_q && ctrl_q[CTRL_TXDIE],
                      rx_full_q && !err_any && ctrl_q[CTRL_RXIE],
                      err_any && ctrl_q[CTRL_RXIE]};

  // Read answer lasts one cycle; requests lag their flags by one edge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_q <= 8'h00;
      irq_q   <= 4'h0;
    end
    else
    begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      irq_q   <= irq_d;
    end
  end

  // Every output is taken straight from a flip-flop
  assign reg_rdata    = rdata_q;
  assign tx_pin       = tx_pin_q;
  assign tx_pin_oe    = ctrl_q[CTRL_TXEN];
  assign sck_out      = sck_gen_q;
  assign sck_oe       = sck_oe_q;
  assign tx_empty_irq = irq_q[3];
  assign tx_done_irq  = irq_q[2];
  assign rx_full_irq  = irq_q[1];
  assign rx_error_irq = irq_q[0];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Last rise of a character with nothing waiting to follow it
  sequence s_bit7_rise_no_data;
    rise_ev && tx_bit7 && !tx_avail && te && !te_clear;
  endsequence

  // First falling event after a load puts out bit 0
  sequence s_first_fall;
    fall_ev && (tx_state_q == CSSM_TX_READY) && te && !te_clear;
  endsequence

  chk_clock_rests_high: assert property (int_clk && !clk_need && sck_gen_q ##1 int_clk |-> sck_gen_q)
    else $error("internal clock left high rest while idle");
  chk_load_sets_empty: assert property (tx_take && !te_clear |=> tx_empty_q && tx_state_q == CSSM_TX_READY)
    else $error("load did not set empty flag");
  chk_lsb_goes_first: assert property (s_first_fall |=> tx_pin_q == $past(tx_shift_q[0]) && tx_cnt_q == 3'h0)
    else $error("first bit driven is not the LSB");
  chk_line_holds_last: assert property (s_bit7_rise_no_data |=>
    tx_state_q == CSSM_TX_IDLE ##0 $stable(tx_pin_q))
    else $error("line did not hold last bit");
  chk_disable_resets_tx: assert property (te_clear |=>
    tx_empty_q && tx_state_q == CSSM_TX_IDLE && tx_shift_q == 8'h00)
    else $error("transmit disable did not reset transmitter");
  chk_rx_off_keeps: assert property (!rx_on |=>
    $stable(rx_hold_q) && (rx_full_q || !$past(rx_full_q) || $past(rxf_clr)))
    else $error("receiver off changed held data");
  chk_overrun_no_copy: assert property (ovr_set |=> overrun_q && $stable(rx_hold_q))
    else $error("overrun not flagged or data copied");
  chk_copy_when_free: assert property (rx_copy |=> rx_full_q && rx_hold_q == $past(rx_next))
    else $error("received character not copied");
  chk_error_blocks: assert property (err_any |-> !tx_take && !rx_done)
    else $error("error flag did not block transfers");
  chk_dma_clears: assert property (dma_access && wr_txhold && !tx_take && !te_clear |=> !tx_empty_q)
    else $error("dma write did not clear empty flag");
  // Requests are registered, so each one follows its flag after one edge
  chk_error_irq: assert property (overrun_q && ctrl_q[CTRL_RXIE] |=> rx_error_irq && !rx_full_irq)
    else $error("overrun did not raise error request");
  chk_full_sets_irq: assert property (rx_full_q && !err_any && ctrl_q[CTRL_RXIE] |=> rx_full_irq)
    else $error("full flag did not raise full request");

  // Quiet-state checks: line, clock pin and receive counter; then the done flag set check
  chk_pin_fall_only: assert property (!fall_ev |=> $stable(tx_pin_q))
    else $error("transmit line moved off a falling edge");
  chk_clock_pin_high: assert property (!int_clk |=> sck_gen_q)
    else $error("clock output not high without internal clock");
  chk_rx_count_idle: assert property (!rx_on |=> rx_cnt_q == 3'h0)
    else $error("receive counter not cleared while off");
  chk_done_at_bit7: assert property (tx_done_set |=> tx_done_q)
    else $error("done flag not set after last bit");

endmodule

// File: cssm_peer.sv
`timescale 1ns/1ps
module cssm_peer
  import cssm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       sck_line,
  input  wire logic       tx_line,
  output logic            rx_line,
  output logic            sck_ext,
  output logic            got_valid,
  output logic      [7:0] got_byte
);

  // ****************************************
  // Far-side serial device state
  // ****************************************
  logic [7:0] out_q[$];  // Characters waiting to go toward the block
  logic [7:0] cur_q;     // Character now on the receive line
  logic [7:0] in_q;      // Transmit bits collected so far
  int         out_n;     // Bits sent of the current character
  int         in_n;      // Bits collected of the current character
  int         idle_n;    // Cycles since the last rising edge
  logic       busy_q;    // A character is being sent
  logic       sck_q;     // Serial clock one cycle ago

  initial
  begin
    rx_line   = 1'b1;
    sck_ext   = 1'b1;
    got_valid = 1'b0;
    got_byte  = 8'h00;
    busy_q    = 1'b0;
    sck_q     = 1'b1;
    out_n     = 0;
    in_n      = 0;
    idle_n    = 0;
    in_q      = 8'h00;
    cur_q     = 8'h00;
  end

  // Edge watcher: drive on falling edges, sample on rising edges
  always @(posedge mclk)
  begin
    got_valid <= 1'b0;
    sck_q     <= sck_line;
    idle_n    = idle_n + 1;
    if (sck_q && !sck_line)
    begin
      // Falling edge opens a new bit cell
      if (!busy_q && out_q.size() > 0)
      begin
        cur_q  = out_q.pop_front();
        busy_q = 1'b1;
        out_n  = 0;
      end
      if (busy_q)
        rx_line <= cur_q[out_n];
    end
    else if (!sck_q && sck_line)
    begin
      // Rising edge: the block's bit is valid here, LSB arrives first
      idle_n = 0;
      in_q   = {tx_line, in_q[7:1]};
      in_n   = in_n + 1;
      if (busy_q)
        out_n = out_n + 1;
      if (out_n == 8)
        busy_q = 1'b0;
      if (in_n == 8)
      begin
        got_valid <= 1'b1;
        got_byte  <= in_q;
        in_n      = 0;
      end
    end
    // Released line wanders so a stale bit can never be mistaken for data
    if (!busy_q && idle_n > 6)
      rx_line <= ~rx_line;
  end

  // External clock source: eight pulses per character, idles high
  task automatic gen_clock(input int half);
    repeat (8)
    begin
      repeat (half) @(posedge mclk);
      sck_ext <= 1'b0;
      repeat (half) @(posedge mclk);
      sck_ext <= 1'b1;
    end
  endtask

endmodule

// File: clocked_serial_sync_mode_bench.sv
`timescale 1ns/1ps
module clocked_serial_sync_mode_bench
  import cssm_pkg::*;
();

  // ****************************************
  // Signals
  // ****************************************
  logic       mclk;
  logic       sys_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic       dma_access;
  logic [7:0] reg_rdata;
  logic       tx_pin;
  logic       tx_pin_oe;
  logic       rx_line;
  logic       sck_out;
  logic       sck_oe;
  logic       sck_ext;
  logic       tx_empty_irq;
  logic       tx_done_irq;
  logic       rx_full_irq;
  logic       rx_error_irq;
  logic       got_valid;
  logic [7:0] got_byte;
  logic       rd_pend;      // Read strobe seen at the last edge
  logic [7:0] exp_rd[$];    // Expected read data, oldest first
  logic [7:0] exp_tx[$];    // Expected characters at the far side
  logic [7:0] b[4];         // Transmit characters
  logic [7:0] r[4];         // Receive characters
  int         n_tests;
  int         fail_count;
  int         seed;
  int         k;
  // Shared clock pin: whoever has the enable owns the level
  wire        sck_line = sck_oe ? sck_out : sck_ext;

  cssm_serial u_dut (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .dma_access   (dma_access),
    .reg_rdata    (reg_rdata),
    .tx_pin       (tx_pin),
    .tx_pin_oe    (tx_pin_oe),
    .rx_pin       (rx_line),
    .sck_in       (sck_line),
    .sck_out      (sck_out),
    .sck_oe       (sck_oe),
    .tx_empty_irq (tx_empty_irq),
    .tx_done_irq  (tx_done_irq),
    .rx_full_irq  (rx_full_irq),
    .rx_error_irq (rx_error_irq)
  );

  cssm_peer u_peer (
    .mclk      (mclk),
    .sck_line  (sck_line),
    .tx_line   (tx_pin),
    .rx_line   (rx_line),
    .sck_ext   (sck_ext),
    .got_valid (got_valid),
    .got_byte  (got_byte)
  );

  // 40 MHz system clock
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write cycle, then one idle cycle so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic dma);
    reg_addr   <= a;
    reg_wdata  <= d;
    reg_wr     <= 1'b1;
    dma_access <= dma;
    @(posedge mclk);
    reg_wr     <= 1'b0;
    dma_access <= 1'b0;
    @(posedge mclk);
  endtask

  // One read cycle; the monitor compares the answer
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic dma);
    exp_rd.push_back(e);
    reg_addr   <= a;
    reg_rd     <= 1'b1;
    dma_access <= dma;
    @(posedge mclk);
    reg_rd     <= 1'b0;
    dma_access <= 1'b0;
    @(posedge mclk);
  endtask

  // Queue a character each way and hand one to the transmitter
  task automatic send(input logic [7:0] tb_byte, input logic [7:0] rb_byte, input logic dma);
    exp_tx.push_back(tb_byte);
    u_peer.out_q.push_back(rb_byte);
    wr(ADDR_TXHOLD, tb_byte, dma);
    if (!dma)
      wr(ADDR_STAT, 8'h7f, 1'b0);
  endtask

  // Bounded wait for a request line; one edge passes first so a stale level cannot satisfy it
  task automatic wait_for(ref logic s, input string what);
    int i;
    @(posedge mclk);
    for (i = 0; i < 600 && s !== 1'b1; i++)
      @(posedge mclk);
    check(what, {7'h00, s}, 8'h01);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // Monitor: results against the oldest note
  // ****************************************
  always @(posedge mclk)
  begin
    if (rd_pend)
      check("reg_rdata", reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 8'hxx);
    if (got_valid)
      check("tx_byte", got_byte, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
    rd_pend <= reg_rd;
  end

  // Watchdog well beyond the expected run of about 900 cycles
  initial
  begin
    repeat (30000) @(posedge mclk);
    fail_count++;
    stop_test;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    n_tests    = 0;
    fail_count = 0;
    rd_pend    = 1'b0;
    sys_rst    = 1'b1;
    reg_addr   = 3'h0;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    dma_access = 1'b0;
    seed       = $urandom(32'h55e0);
    for (k = 0; k < 4; k++)
    begin
      b[k] = 8'($urandom);
      r[k] = 8'($urandom);
    end
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    check("sck_out", {7'h00, sck_out}, 8'h01);
    check("tx_pin_oe", {7'h00, tx_pin_oe}, 8'h00);
    rd(ADDR_STAT, 8'h80, 1'b0);
    rd(ADDR_CTRL, 8'h00, 1'b0);
    rd(3'h6, 8'h00, 1'b0);
    // Enables off, format, divisor, clock source, 20 idle cycles, enables
    wr(ADDR_CTRL, 8'h00, 1'b0);
    wr(ADDR_MODE, 8'h80, 1'b0);
    wr(ADDR_DIV, 8'h07, 1'b0);
    wr(ADDR_CTRL, 8'h00, 1'b0);
    repeat (20) @(posedge mclk);
    wr(ADDR_CTRL, 8'hf4, 1'b0);
    check("sck_oe", {7'h00, sck_oe}, 8'h01);
    // Back-to-back pair, second loaded by a DMA write
    rd(ADDR_STAT, 8'h80, 1'b0);
    send(b[0], r[0], 1'b0);
    wait_for(tx_empty_irq, "tx_empty_irq");
    send(b[1], r[1], 1'b1);
    wait_for(rx_full_irq, "rx_full_irq");
    rd(ADDR_RXHOLD, r[0], 1'b1);
    wait_for(tx_done_irq, "tx_done_irq");
    wait_for(rx_full_irq, "rx_full_irq");
    repeat (4) @(posedge mclk);
    check("tx_pin", {7'h00, tx_pin}, {7'h00, b[1][7]});
    check("sck_out", {7'h00, sck_out}, 8'h01);
    rd(ADDR_STAT, 8'hc4, 1'b0);
    // Full flag left set: next character overruns
    send(b[2], r[2], 1'b0);
    wait_for(rx_error_irq, "rx_error_irq");
    rd(ADDR_STAT, 8'he4, 1'b0);
    rd(ADDR_RXHOLD, r[1], 1'b0);
    // Overrun holds the transmitter until cleared
    send(b[3], r[3], 1'b0);
    repeat (60) @(posedge mclk);
    check("sck_out", {7'h00, sck_out}, 8'h01);
    rd(ADDR_STAT, 8'h64, 1'b0);
    wr(ADDR_STAT, 8'h9f, 1'b0);
    wait_for(rx_full_irq, "rx_full_irq");
    // Receiver disable keeps flags and data
    wr(ADDR_CTRL, 8'he4, 1'b0);
    rd(ADDR_STAT, 8'hc4, 1'b0);
    rd(ADDR_RXHOLD, r[3], 1'b0);
    // External clock from the far side
    wr(ADDR_STAT, 8'hbf, 1'b0);
    wr(ADDR_CTRL, 8'h36, 1'b0);
    // The pin enable follows the clock select one edge later
    @(posedge mclk);
    check("sck_oe", {7'h00, sck_oe}, 8'h00);
    send(r[0], b[0], 1'b0);
    repeat (6) @(posedge mclk);
    u_peer.gen_clock(10);
    repeat (10) @(posedge mclk);
    rd(ADDR_RXHOLD, b[0], 1'b0);
    repeat (10) @(posedge mclk);
    check("tx_queue", 8'(exp_tx.size()), 8'h00);
    stop_test;
  end

endmodule
